/* common/sync_regs_pkg.sv */
// constants, register map and state records for the sync, spi and pll block
package sync_regs_pkg;

	// register offsets on the internal register port
	localparam logic [7:0] SYNC_STATUS_OFS   = 8'hD3;
	localparam logic [7:0] READBACK_SEL_OFS  = 8'hD4;
	localparam logic [7:0] PLL_SETTLE_OFS    = 8'hD5;
	localparam logic [7:0] LP_TIMEOUT_HI_OFS = 8'hD2;

	// field positions and reset values
	localparam int          RESPONSE_FLAG_BIT = 0;
	localparam logic [7:0]  READBACK_RST      = 8'hFA;
	localparam logic [15:0] PLL_SETTLE_RST    = 16'h1450;
	localparam logic [15:0] LP_TIMEOUT_HI_RST = 16'h0000;

	// lock wait timing, reference clock assumed at 10 MHz
	localparam int REF_FREQ_MHZ     = 10;
	localparam int PLL_LOCK_MAX_US  = 500;
	localparam int PLL_LOCK_MIN_CNT = PLL_LOCK_MAX_US * REF_FREQ_MHZ;

	typedef enum logic [1:0] {
		PLL_OFF    = 2'b00,
		PLL_WAIT   = 2'b01,
		PLL_LOCKED = 2'b10
	} pll_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        flag;
		logic        pulse;
		logic [7:0]  rb_addr;
		logic [15:0] settle;
		logic [15:0] lp_hi;
		logic [15:0] rdata;
		logic        rvalid;
		pll_state_t  pll_state;
		logic [15:0] pll_cnt;
		logic        pll_locked;
	} regs_state_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        expired;
		logic        err_pulse;
	} timer_state_t;

endpackage

/* design/lp_rx_timer.sv */
// low-power receive timeout counter
`timescale 1ns/10ps
module lp_rx_timer (
	input  logic        clk,
	input  logic        resetn,
	input  logic        lp_rx_mode,
	input  logic        ref_tick,
	input  logic [31:0] compare,
	output logic        lp_timeout_error,
	output logic        lp_tx_forced
);

	sync_regs_pkg::timer_state_t s;
	sync_regs_pkg::timer_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.err_pulse = 1'b0;
		if (!lp_rx_mode) begin
			next_s.cnt = 32'h0000_0000;
			next_s.expired = 1'b0;
		end else if (ref_tick && !s.expired) begin
			if (s.cnt == compare) begin
				next_s.expired = 1'b1;
				next_s.err_pulse = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign lp_timeout_error = s.err_pulse;
	// expiry holds the lane at lp11 in transmit until the mode is left
	assign lp_tx_forced     = s.expired;

	chk_timer_expire: assert property (
		@(posedge clk) disable iff (!resetn)
		lp_rx_mode && ref_tick && !s.expired && s.cnt == compare
		|=> lp_timeout_error && lp_tx_forced)
		else $error("timer did not expire at compare");

	chk_timer_exit: assert property (
		@(posedge clk) disable iff (!resetn)
		!lp_rx_mode |=> s.cnt == 32'h0000_0000 && !lp_tx_forced)
		else $error("timer not reset on mode exit");

endmodule // lp_rx_timer

/* design/sync_spi_pll_misc_regs.sv */
// sync response, spi readback, pll lock wait and lp timeout registers
//
// Notes on behaviour
// - a sync response from the link sets flag bit 0; reads 0 before.
// - sync output pin goes high in the same cycle the flag sets.
// - writing 1 to bit 0 clears the flag; writing 0 leaves it.
// - clearing the flag drives the sync output pin low.
// - spi reads return the register named by the 8-bit select, reset 0xFA.
// - the 16-bit settle count sets the lock wait in reference cycles.
// - settle count resets to 0x1450, about 520 us at 10 MHz.
// - count times reference period must cover the 500 us lock time.
// - settle count writes are ignored while pll power is on.
// - second timer register holds part of the 32-bit timeout compare.
// - lp receive timer counts in mode, resets on exit, errors on expiry.
`timescale 1ns/10ps
module sync_spi_pll_misc_regs (
	input  logic                     clk,
	input  logic                     resetn,
	input  sync_regs_pkg::reg_req_t  reg_req,
	output logic [15:0]              reg_rdata,
	output logic                     reg_rvalid,
	input  logic                     sync_response_in,
	output logic                     sync_pulse_out,
	output logic [7:0]               readback_reg_addr,
	input  logic                     pll_power_on,
	input  logic                     ref_tick,
	output logic                     pll_locked,
	input  logic                     lp_rx_mode,
	input  logic [15:0]              lp_timeout_low,
	output logic                     lp_timeout_error,
	output logic                     lp_tx_forced
);

	sync_regs_pkg::regs_state_t s;
	sync_regs_pkg::regs_state_t next_s;
	logic [31:0]                timeout_compare;

	function automatic logic hit(input sync_regs_pkg::reg_req_t r,
		input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;

		// sticky response flag, a new response wins over a clear
		if (reg_req.wr && hit(reg_req, sync_regs_pkg::SYNC_STATUS_OFS)
			&& reg_req.wdata[sync_regs_pkg::RESPONSE_FLAG_BIT]) begin
			next_s.flag = 1'b0;
		end
		if (sync_response_in) begin
			next_s.flag = 1'b1;
		end
		// pin register loads the same next value as the flag
		next_s.pulse = next_s.flag;

		if (reg_req.wr && hit(reg_req, sync_regs_pkg::READBACK_SEL_OFS)) begin
			next_s.rb_addr = reg_req.wdata[7:0];
		end
		if (reg_req.wr && hit(reg_req, sync_regs_pkg::PLL_SETTLE_OFS)
			&& !pll_power_on) begin
			next_s.settle = reg_req.wdata;
		end
		if (reg_req.wr && hit(reg_req, sync_regs_pkg::LP_TIMEOUT_HI_OFS)) begin
			next_s.lp_hi = reg_req.wdata;
		end

		if (reg_req.rd) begin
			next_s.rvalid = 1'b1;
			case (reg_req.addr)
				sync_regs_pkg::SYNC_STATUS_OFS: begin
					next_s.rdata = {15'h0000, s.flag};
				end
				sync_regs_pkg::READBACK_SEL_OFS: begin
					next_s.rdata = {8'h00, s.rb_addr};
				end
				sync_regs_pkg::PLL_SETTLE_OFS: begin
					next_s.rdata = s.settle;
				end
				sync_regs_pkg::LP_TIMEOUT_HI_OFS: begin
					next_s.rdata = s.lp_hi;
				end
				default: begin
					next_s.rdata = 16'h0000;
				end
			endcase
		end

		// lock wait in reference cycles after power-on
		case (s.pll_state)
			sync_regs_pkg::PLL_OFF: begin
				next_s.pll_cnt = 16'h0000;
				if (pll_power_on) begin
					next_s.pll_state = sync_regs_pkg::PLL_WAIT;
				end
			end
			sync_regs_pkg::PLL_WAIT: begin
				if (!pll_power_on) begin
					next_s.pll_state = sync_regs_pkg::PLL_OFF;
				end else if (ref_tick) begin
					if (s.pll_cnt + 16'h0001 >= s.settle) begin
						next_s.pll_state = sync_regs_pkg::PLL_LOCKED;
					end else begin
						next_s.pll_cnt = s.pll_cnt + 16'h0001;
					end
				end
			end
			sync_regs_pkg::PLL_LOCKED: begin
				if (!pll_power_on) begin
					next_s.pll_state = sync_regs_pkg::PLL_OFF;
				end
			end
			default: begin
				next_s.pll_state = sync_regs_pkg::PLL_OFF;
			end
		endcase
		next_s.pll_locked = next_s.pll_state == sync_regs_pkg::PLL_LOCKED;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s.flag       <= 1'b0;
			s.pulse      <= 1'b0;
			s.rb_addr    <= sync_regs_pkg::READBACK_RST;
			s.settle     <= sync_regs_pkg::PLL_SETTLE_RST;
			s.lp_hi      <= sync_regs_pkg::LP_TIMEOUT_HI_RST;
			s.rdata      <= 16'h0000;
			s.rvalid     <= 1'b0;
			s.pll_state  <= sync_regs_pkg::PLL_OFF;
			s.pll_cnt    <= 16'h0000;
			s.pll_locked <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// second register supplies the upper half of the compare value
	assign timeout_compare = {s.lp_hi, lp_timeout_low};

	lp_rx_timer u_lp_rx_timer (
		.clk              (clk),
		.resetn           (resetn),
		.lp_rx_mode       (lp_rx_mode),
		.ref_tick         (ref_tick),
		.compare          (timeout_compare),
		.lp_timeout_error (lp_timeout_error),
		.lp_tx_forced     (lp_tx_forced)
	);

	assign reg_rdata         = s.rdata;
	assign reg_rvalid        = s.rvalid;
	assign sync_pulse_out    = s.pulse;
	assign readback_reg_addr = s.rb_addr;
	assign pll_locked        = s.pll_locked;

	chk_flag_sets: assert property (
		@(posedge clk) disable iff (!resetn)
		sync_response_in |=> s.flag ##0 sync_pulse_out)
		else $error("response did not set flag");

	chk_pin_follows: assert property (
		@(posedge clk) disable iff (!resetn)
		sync_pulse_out == s.flag)
		else $error("sync pin differs from flag");

	chk_clear_w1c: assert property (
		@(posedge clk) disable iff (!resetn)
		reg_req.wr && reg_req.addr == sync_regs_pkg::SYNC_STATUS_OFS
		&& reg_req.wdata[0] && !sync_response_in
		|=> !s.flag && !sync_pulse_out)
		else $error("write one did not clear flag");

	chk_zero_keeps: assert property (
		@(posedge clk) disable iff (!resetn)
		s.flag && !(reg_req.wr && reg_req.addr ==
		sync_regs_pkg::SYNC_STATUS_OFS && reg_req.wdata[0])
		|=> sync_pulse_out)
		else $error("sync pin fell without clear");

	chk_select_write: assert property (
		@(posedge clk) disable iff (!resetn)
		reg_req.wr && reg_req.addr == sync_regs_pkg::READBACK_SEL_OFS
		|=> readback_reg_addr == $past(reg_req.wdata[7:0]))
		else $error("readback select not written");

	chk_lock_wait: assert property (
		@(posedge clk) disable iff (!resetn)
		s.pll_state == sync_regs_pkg::PLL_WAIT && pll_power_on && ref_tick
		&& s.pll_cnt + 16'h0001 >= s.settle |=> pll_locked)
		else $error("pll lock not reached at count");

	chk_no_early_lock: assert property (
		@(posedge clk) disable iff (!resetn)
		!pll_power_on |=> !pll_locked)
		else $error("lock shown while pll off");

	chk_reset_covers: assert property (
		@(posedge clk)
		!resetn ##1 !resetn
		|-> int'(s.settle) >= sync_regs_pkg::PLL_LOCK_MIN_CNT)
		else $error("reset settle count too short");

	chk_settle_guard: assert property (
		@(posedge clk) disable iff (!resetn)
		pll_power_on |=> $stable(s.settle))
		else $error("settle count changed while pll on");

	chk_reserved_zero: assert property (
		@(posedge clk) disable iff (!resetn)
		reg_req.rd && reg_req.addr == sync_regs_pkg::SYNC_STATUS_OFS
		|=> reg_rvalid && reg_rdata[15:1] == 15'h0000)
		else $error("reserved status bits not zero");

endmodule // sync_spi_pll_misc_regs

/* dv/host_model.sv */
// host processor model that drives the register port
`timescale 1ns/10ps
module host_model (
	input  wire logic                     clk,
	input  wire logic [15:0]              rdata,
	input  wire logic                     rvalid,
	output sync_regs_pkg::reg_req_t       req
);
	initial req = '0;

	// released fields show the inverse so a stale value cannot pass
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d,
			output logic v);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
		d = rdata;
		v = rvalid;
	endtask
endmodule // host_model

/* dv/tb_sync_spi_pll_misc_regs.sv */
// testbench for the sync, spi readback, pll and lp timeout registers
`timescale 1ns/10ps
module tb_sync_spi_pll_misc_regs;
	logic                    clk = 1'b0;
	logic                    resetn = 1'b0;
	sync_regs_pkg::reg_req_t req;
	logic [15:0]             rdata;
	logic                    rvalid, sync_in, pulse, pwr, tick, locked;
	logic                    lp_mode, lp_err, lp_forced;
	logic [15:0]             lp_low = 16'h0001;
	logic [7:0]              rb_addr;
	int                      n_fail = 0;
	int                      samples_checked = 0;

	always #2 clk = ~clk;
	initial {sync_in, pwr, tick, lp_mode} = '0;

	host_model u_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

	sync_spi_pll_misc_regs u_dut (
		.clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .sync_response_in(sync_in),
		.sync_pulse_out(pulse), .readback_reg_addr(rb_addr),
		.pll_power_on(pwr), .ref_tick(tick), .pll_locked(locked),
		.lp_rx_mode(lp_mode), .lp_timeout_low(lp_low),
		.lp_timeout_error(lp_err), .lp_tx_forced(lp_forced)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		u_host.rd(a, d, v);
		check(16'(v), 16'h0001);
		check(d, exp);
	endtask

	task automatic pulse_tick();
		@(negedge clk);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
	endtask

	task automatic test_reset_values();
		rchk(8'hD3, 16'h0000);
		rchk(8'hD4, 16'h00FA);
		rchk(8'hD5, 16'h1450);
		check(16'(rb_addr), 16'h00FA);
		check(16'(pulse), 16'h0000);
	endtask

	// lock wait at the reset count, one reference tick every cycle
	task automatic test_reset_lock();
		int n;
		n = 0;
		@(negedge clk);
		pwr = 1'b1;
		@(negedge clk);
		tick = 1'b1;
		while (!locked && n < 6000) begin
			@(negedge clk);
			n++;
		end
		tick = 1'b0;
		pwr = 1'b0;
		check(16'(locked), 16'h0001);
		check(16'(n), sync_regs_pkg::PLL_SETTLE_RST);
		check(16'(n >= sync_regs_pkg::PLL_LOCK_MIN_CNT), 16'h0001);
		repeat (2) @(negedge clk);
	endtask

	task automatic test_sync_flag();
		@(negedge clk);
		sync_in = 1'b1;
		@(negedge clk);
		sync_in = 1'b0;
		check(16'(pulse), 16'h0001);
		rchk(8'hD3, 16'h0001);
		u_host.wr(8'hD3, 16'hFFFE);
		check(16'(pulse), 16'h0001);
		u_host.wr(8'hD3, 16'h0001);
		check(16'(pulse), 16'h0000);
		rchk(8'hD3, 16'h0000);
		// a response in the same cycle as a clear must win
		fork
			u_host.wr(8'hD3, 16'h0001);
			begin
				@(negedge clk);
				sync_in = 1'b1;
				@(negedge clk);
				sync_in = 1'b0;
			end
		join
		check(16'(pulse), 16'h0001);
		u_host.wr(8'hD3, 16'h0001);
		check(16'(pulse), 16'h0000);
	endtask

	task automatic test_readback();
		u_host.wr(8'hD4, 16'hFF12);
		check(16'(rb_addr), 16'h0012);
		rchk(8'hD4, 16'h0012);
		u_host.wr(8'hD7, 16'h5555);
		rchk(8'hD7, 16'h0000);
	endtask

	task automatic test_pll_lock();
		u_host.wr(8'hD5, 16'h0002);
		@(negedge clk);
		pwr = 1'b1;
		@(negedge clk);
		u_host.wr(8'hD5, 16'h0009);
		rchk(8'hD5, 16'h0002);
		pulse_tick();
		check(16'(locked), 16'h0000);
		pulse_tick();
		check(16'(locked), 16'h0001);
		pwr = 1'b0;
		repeat (2) @(negedge clk);
		check(16'(locked), 16'h0000);
	endtask

	task automatic test_lp_timer();
		u_host.wr(8'hD2, 16'hA5C3);
		rchk(8'hD2, 16'hA5C3);
		u_host.wr(8'hD2, 16'h0000);
		lp_mode = 1'b1;
		pulse_tick();
		check(16'(lp_err), 16'h0000);
		pulse_tick();
		check(16'(lp_err), 16'h0001);
		check(16'(lp_forced), 16'h0001);
		@(negedge clk);
		check(16'(lp_err), 16'h0000);
		lp_mode = 1'b0;
		repeat (2) @(negedge clk);
		check(16'(lp_forced), 16'h0000);
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		test_reset_values();
		test_reset_lock();
		test_sync_flag();
		test_readback();
		test_pll_lock();
		test_lp_timer();
		results();
	end

	initial begin
		#60000;
		n_fail++;
		results();
	end
endmodule // tb_sync_spi_pll_misc_regs
